// [hw/ffh_core.sv]
// Purpose: Fault flag, halt-on-fault, analysis halt and pointer capture.
// Assumes: Processor event inputs are on clk_sys_i; pins are asynchronous.
// Notes:   All state freezes while ce_i is low.
//
// The register addresses and strobed register access were left to the implementer.
module ffh_core
    import ffh_pkg::*;
(
    input  wire logic        clk_sys_i,        // Processor clock, 20 MHz.
    input  wire logic        rst_b_i,          // Power-on reset, active low.
    input  wire logic        ce_i,             // Clock enable.
    // Register port.
    input  wire logic [3:0]  reg_addr_i,       // Byte address.
    input  wire logic [31:0] reg_wdata_i,      // Write data.
    input  wire logic        reg_we_i,         // Write strobe.
    input  wire logic        reg_re_i,         // Read strobe.
    output logic      [31:0] reg_rdata_o,      // Read data, one cycle later.
    // Asynchronous pins.
    input  wire logic        chained_fault_i,  // Fault from the previous device.
    input  wire logic        analyse_i,        // Analysis request.
    input  wire logic        reset_pin_i,      // Processor reset pin, high active.
    // Execution unit, same clock.
    input  wire logic        ovf_i,            // Arithmetic overflow.
    input  wire logic        div0_i,           // Division by zero.
    input  wire logic        bound_i,          // Array bound violation.
    input  wire logic        fault_test_i,     // Fault-test instruction executes.
    input  wire logic [31:0] instr_ip_i,       // Address of executing instruction.
    input  wire logic        preempt_i,        // High priority pre-empts low.
    input  wire logic        hp_done_i,        // High priority work finished.
    input  wire logic        desched_i,        // Descheduling point reached.
    // Outputs.
    output logic             fault_o,          // Fault pin.
    output logic             proc_run_o,       // Processes may run.
    output logic             links_halt_o,     // Links finish then go idle.
    output logic             out_fetch_en_o,   // Output links may fetch memory.
    output logic             refresh_en_o,     // Memory refresh enable.
    output logic             bpj_en_o,         // Breakpoint jump enable flag.
    output logic      [31:0] areg_o            // Top evaluation-stack register.
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [2:0]  s1_q, s2_q, s3_q;    // Pin chains: chained, analyse, reset.
    logic [2:0]  filt_q, filt_d;      // Filtered pin levels.
    ffh_state_e  st_q, st_d;          // Halt state.
    logic        fault_q, fault_d;    // Internal fault flag.
    logic        hof_q, hof_d;        // Halt-on-fault flag.
    logic        bpj_q, bpj_d;        // Breakpoint jump enable.
    logic        refr_q, refr_d;      // Refresh enable.
    logic        cause_q, cause_d;    // One when halted by analysis.
    logic        hp_q, hp_d;          // High-priority work active.
    logic [5:0]  rcnt_q, rcnt_d;      // Reset pin high length.
    logic [31:0] ip_q, ip_d;          // Captured pointer.
    logic [31:0] areg_q, areg_d;      // Top stack register.
    logic [31:0] rdata_q, rdata_d;    // Read data.
    logic        chain_s, anl_s, rst_s;
    logic        ctrl_wr;             // Write to control register.
    logic        fault_rise;          // A set on a clear flag with halt-on-fault on, no restore.
    logic        fault_set;           // A set event this cycle.
    logic        restore;             // Saved pair comes back this cycle.
    logic        rst_event;           // Qualified reset release.

    ffh_save_if save ();

    // Advances a pointer by a fixed number of bytes.
    function automatic logic [31:0] ip_adv(input logic [31:0] ip, input logic [31:0] n);
        ip_adv = ip + n;
    endfunction

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // Only the second stage reads the first; the filter compares two and three.
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s1_q <= 3'h0;
            s2_q <= 3'h0;
            s3_q <= 3'h0;
        end else if (ce_i) begin
            s1_q <= {reset_pin_i, analyse_i, chained_fault_i};
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Filtered levels move only when the last two stages agree.
    always_comb begin
        filt_d = filt_q;
        for (int i = 0; i < 3; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                filt_d[i] = s3_q[i];
            end
        end
    end

    assign chain_s = filt_q[0];
    assign anl_s   = filt_q[1];
    assign rst_s   = filt_q[2];

    // ------------------------------------------------------------------
    // Flag and halt next-state logic
    // ------------------------------------------------------------------
    assign ctrl_wr   = reg_we_i && (reg_addr_i == ADDR_CTRL);
    // A short reset pulse is not trusted; only a full-width one counts.
    assign rst_event = filt_q[2] && !filt_d[2] && (rcnt_q >= RST_MIN_CNT);

    always_comb begin
        st_d    = st_q;
        hof_d   = hof_q;
        bpj_d   = bpj_q;
        refr_d  = refr_q;
        cause_d = cause_q;
        hp_d    = hp_q;
        ip_d    = ip_q;
        areg_d  = areg_q;
        fault_d = fault_q;
        rcnt_d  = rst_s ? ((rcnt_q == 6'h3f) ? rcnt_q : rcnt_q + 6'h01) : 6'h00;
        // Clear comes first so that a set in the same cycle wins.
        if (fault_test_i) begin
            fault_d = 1'b0;
        end
        if (fault_set) begin
            fault_d = 1'b1;
        end
        if (ctrl_wr) begin
            hof_d  = reg_wdata_i[CTRL_HOF_BIT];
            bpj_d  = reg_wdata_i[CTRL_BPJ_BIT];
            refr_d = reg_wdata_i[CTRL_REFRESH_BIT];
        end
        // Pre-emption keeps the live pair as the high-priority copy.
        if (preempt_i && !hp_q) begin
            hp_d = 1'b1;
        end else if (hp_done_i && hp_q) begin
            hp_d    = 1'b0;
            fault_d = save.rd_flags[0];
            hof_d   = save.rd_flags[1];
        end
        case (st_q)
            ST_RUN: begin
                if (fault_rise) begin
                    st_d    = ST_HALTED;
                    cause_d = 1'b0;
                    ip_d    = ip_adv(instr_ip_i, IP_FAULT_ADV);
                    areg_d  = ip_adv(instr_ip_i, IP_FAULT_ADV);
                end else if (anl_s) begin
                    st_d = ST_WAIT_DESCHED;
                end
            end
            ST_WAIT_DESCHED: begin
                // High-priority work runs to completion before the stop.
                if (fault_rise) begin
                    st_d    = ST_HALTED;
                    cause_d = 1'b0;
                    ip_d    = ip_adv(instr_ip_i, IP_FAULT_ADV);
                    areg_d  = ip_adv(instr_ip_i, IP_FAULT_ADV);
                end else if (desched_i && !hp_q) begin
                    st_d    = ST_HALTED;
                    cause_d = 1'b1;
                    ip_d    = ip_adv(instr_ip_i, IP_ANALYSE_ADV);
                    areg_d  = ip_adv(instr_ip_i, IP_ANALYSE_ADV);
                end
            end
            ST_HALTED: begin
                st_d = ST_HALTED;
            end
            default: begin
                st_d = ST_RUN;
            end
        endcase
        // A full reset pulse restarts the processor; the fault flag stays.
        if (rst_event) begin
            st_d    = ST_RUN;
            cause_d = 1'b0;
            hp_d    = 1'b0;
            if (!anl_s) begin
                hof_d = HOF_RST;
                bpj_d = BPJ_RST;
            end
        end
    end

    // Sources that set the flag; a fault-test in the same cycle loses to them.
    assign fault_set  = ovf_i || div0_i || bound_i || (ctrl_wr && reg_wdata_i[CTRL_SETF_BIT]);
    assign restore    = hp_done_i && hp_q;
    // A halt needs a real set while halt-on-fault is already set. A restore
    // that brings back a set low-priority flag is not a new fault. Working
    // from fault_set rather than fault_d also keeps this out of a loop.
    assign fault_rise = !fault_q && fault_set && hof_q && !restore;

    // ------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            filt_q  <= 3'h0;
            st_q    <= ST_RUN;
            fault_q <= FAULT_PWRUP;
            hof_q   <= HOF_RST;
            bpj_q   <= BPJ_RST;
            refr_q  <= REFRESH_RST;
            cause_q <= 1'b0;
            hp_q    <= 1'b0;
            rcnt_q  <= 6'h00;
            ip_q    <= WORD_RST;
            areg_q  <= WORD_RST;
        end else if (ce_i) begin
            filt_q  <= filt_d;
            st_q    <= st_d;
            fault_q <= fault_d;
            hof_q   <= hof_d;
            bpj_q   <= bpj_d;
            refr_q  <= refr_d;
            cause_q <= cause_d;
            hp_q    <= hp_d;
            rcnt_q  <= rcnt_d;
            ip_q    <= ip_d;
            areg_q  <= areg_d;
        end
    end

    // ------------------------------------------------------------------
    // Flag store for pre-emption
    // ------------------------------------------------------------------
    assign save.wr_en    = preempt_i && !hp_q;
    assign save.wr_flags = {hof_q, fault_q};

    ffh_flag_store u_store (
        .clk_sys_i (clk_sys_i),
        .rst_b_i   (rst_b_i),
        .ce_i      (ce_i),
        .save      (save.store)
    );

    // ------------------------------------------------------------------
    // Register read
    // ------------------------------------------------------------------
    // Read data appear in the cycle after the strobe only; unmapped reads zero.
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (reg_re_i) begin
            case (reg_addr_i)
                ADDR_CTRL: begin
                    rdata_d[CTRL_HOF_BIT]     = hof_q;
                    rdata_d[CTRL_BPJ_BIT]     = bpj_q;
                    rdata_d[CTRL_REFRESH_BIT] = refr_q;
                end
                ADDR_STATUS: begin
                    rdata_d[STAT_FAULT_BIT]   = fault_q;
                    rdata_d[STAT_HALTED_BIT]  = (st_q == ST_HALTED);
                    rdata_d[STAT_CAUSE_BIT]   = cause_q;
                    rdata_d[STAT_CHAIN_BIT]   = chain_s;
                    rdata_d[STAT_ANALYSE_BIT] = anl_s;
                    rdata_d[STAT_PREEMPT_BIT] = hp_q;
                end
                ADDR_IPTR: begin
                    rdata_d = ip_q;
                end
                ADDR_TOPREG: begin
                    rdata_d = areg_q;
                end
                default: begin
                    rdata_d = 32'h0000_0000;
                end
            endcase
        end
    end

    // Read data register only.
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_q <= WORD_RST;
        end else if (ce_i) begin
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign reg_rdata_o    = rdata_q;
    assign fault_o        = fault_q | chain_s;
    assign proc_run_o     = (st_q != ST_HALTED);
    assign links_halt_o   = (st_q == ST_HALTED);
    assign out_fetch_en_o = !anl_s;
    assign refresh_en_o   = refr_q;
    assign bpj_en_o       = bpj_q;
    assign areg_o         = areg_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);

    sequence fault_halt_seq;
        ce_i && st_q != ST_HALTED && fault_rise && !rst_event;
    endsequence

    a_fault_pin_or: assert property (fault_o == (fault_q | chain_s))
        else $error("Fault pin is not the OR of flag and chain.");
    a_fault_sticky: assert property (ce_i && fault_q && !fault_test_i && !hp_done_i
        |=> fault_q)
        else $error("Fault flag cleared without fault test.");
    a_fault_set_ovf: assert property (ce_i && ovf_i && !hp_done_i |=> fault_q)
        else $error("Overflow did not set fault flag.");
    a_fault_halt_ip: assert property (fault_halt_seq |=>
        st_q == ST_HALTED && ip_q == $past(instr_ip_i) + 32'h2 && areg_q == ip_q)
        else $error("Fault halt pointer is wrong.");
    a_no_late_halt: assert property (ce_i && st_q == ST_RUN && fault_q && !anl_s
        && !rst_event |=> st_q == ST_RUN)
        else $error("Halt without a fault rise.");
    a_analyse_ip: assert property (ce_i && st_q == ST_WAIT_DESCHED && desched_i && !hp_q
        && !fault_rise && !rst_event |=> cause_q && ip_q == $past(instr_ip_i) + 32'h1)
        else $error("Analysis halt pointer is wrong.");
    a_fetch_stop: assert property (anl_s |-> !out_fetch_en_o)
        else $error("Output fetch enabled under analysis.");
    a_refresh_halted: assert property (ce_i && st_q == ST_HALTED && refr_q && !ctrl_wr
        |=> refresh_en_o)
        else $error("Refresh stopped while halted.");
    a_reset_keeps: assert property (ce_i && rst_event && anl_s && !ctrl_wr && !hp_done_i
        |=> hof_q == $past(hof_q) && bpj_q == $past(bpj_q))
        else $error("Reset under analysis changed flags.");
    a_restore_flags: assert property (ce_i && hp_done_i && hp_q && !rst_event
        |=> {hof_q, fault_q} == $past(save.rd_flags))
        else $error("Flags not restored after high priority.");

endmodule

// [hw/ffh_pkg.sv]
// Purpose: Shared constants for the fault flag and halt control block.
// Assumes: One 20 MHz processor clock; register port with 4-bit byte addresses.
// Notes:   Every offset, field position and count lives here, with the fault, control-flag and word reset values.
package ffh_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL   = 4'h0;  // Control flags, write one to set fault.
    localparam logic [3:0] ADDR_STATUS = 4'h4;  // Live flags and halt state.
    localparam logic [3:0] ADDR_IPTR   = 4'h8;  // Instruction pointer captured at halt.
    localparam logic [3:0] ADDR_TOPREG = 4'hc;  // Top evaluation-stack register.

    // Control register fields.
    localparam int CTRL_HOF_BIT     = 0;  // Halt-on-fault flag.
    localparam int CTRL_BPJ_BIT     = 1;  // Breakpoint jump enable flag.
    localparam int CTRL_SETF_BIT    = 2;  // Write one to set the fault flag.
    localparam int CTRL_REFRESH_BIT = 3;  // Memory refresh enable.

    // Status register fields.
    localparam int STAT_FAULT_BIT   = 0;  // Internal fault flag.
    localparam int STAT_HALTED_BIT  = 1;  // Processor is halted.
    localparam int STAT_CAUSE_BIT   = 2;  // One when the halt came from analysis.
    localparam int STAT_CHAIN_BIT   = 3;  // Synchronised chained fault input.
    localparam int STAT_ANALYSE_BIT = 4;  // Synchronised analysis request.
    localparam int STAT_PREEMPT_BIT = 5;  // High-priority work in progress.

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    // The fault flag has no meaningful power-up value; a constant is used.
    localparam logic       FAULT_PWRUP   = 1'b0;
    localparam logic       HOF_RST       = 1'b0;
    localparam logic       BPJ_RST       = 1'b0;
    localparam logic       REFRESH_RST   = 1'b1;
    localparam logic [31:0] WORD_RST     = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Timing and pointer offsets
    // ------------------------------------------------------------------
    localparam int SYS_CLK_HZ       = 20_000_000;   // Processor clock rate.
    localparam int REF_CLK_NS       = 200;          // Reference clock period.
    localparam int RST_MIN_REF      = 8;            // Least reset width, reference periods.
    // Least reset width in processor cycles, rounded up.
    localparam int RST_MIN_CYC =
        (RST_MIN_REF * REF_CLK_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;
    localparam logic [5:0] RST_MIN_CNT = RST_MIN_CYC[5:0];
    localparam logic [31:0] IP_FAULT_ADV  = 32'h0000_0002;  // Bytes past faulting op.
    localparam logic [31:0] IP_ANALYSE_ADV = 32'h0000_0001; // Bytes past current op.

    // Halt sequencing states.
    typedef enum logic [1:0] {
        ST_RUN,
        ST_WAIT_DESCHED,
        ST_HALTED
    } ffh_state_e;

    // Saved flag pair: bit 1 is halt-on-fault, bit 0 is fault.
    typedef logic [1:0] ffh_flags_t;

endpackage

// [hw/ffh_save_if.sv]
// Purpose: Carries the saved flag pair between the control block and its store.
// Assumes: Same clock on both ends.
// Notes:   Read data are registered inside the store.
interface ffh_save_if;
    logic                wr_en;     // Capture the live flags.
    ffh_pkg::ffh_flags_t wr_flags;  // Flags to keep.
    ffh_pkg::ffh_flags_t rd_flags;  // Flags kept, from a register.

    modport ctrl  (output wr_en, output wr_flags, input rd_flags);
    modport store (input wr_en, input wr_flags, output rd_flags);
endinterface

// [hw/ffh_flag_store.sv]
// Purpose: Holds the low-priority flag pair while high-priority work runs.
// Assumes: One write per pre-emption; writes are frozen with the clock enable.
// Notes:   The output is a register so that restore sees a stable value.
module ffh_flag_store
    import ffh_pkg::*;
(
    input  wire logic  clk_sys_i,   // Processor clock.
    input  wire logic  rst_b_i,     // Asynchronous reset, active low.
    input  wire logic  ce_i,        // Clock enable.
    ffh_save_if.store  save         // Save port.
);

    ffh_flags_t mem_q;   // Stored pair.
    ffh_flags_t mem_d;
    ffh_flags_t rd_q;    // Registered read copy.
    ffh_flags_t rd_d;

    // ------------------------------------------------------------------
    // Next values
    // ------------------------------------------------------------------
    // The copy follows the store one cycle late, which restore tolerates.
    always_comb begin
        mem_d = save.wr_en ? save.wr_flags : mem_q;
        rd_d  = mem_q;
    end

    // Registers only.
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mem_q <= 2'h0;
            rd_q  <= 2'h0;
        end else if (ce_i) begin
            mem_q <= mem_d;
            rd_q  <= rd_d;
        end
    end

    assign save.rd_flags = rd_q;

endmodule

// [bench/ffh_ctrl_model.sv]
// Purpose: Reset and analysis controller, plus the upstream fault neighbour.
// Assumes: Paced by the processor clock; millisecond figures are scaled down.
// Notes:   Pins change by non-blocking assignment just after a rising edge.
module ffh_ctrl_model #(
    parameter int RST_HOLD = 40,    // Reset high, beyond eight reference periods.
    parameter int AN_HOLD  = 8      // Analysis kept up after reset ends.
) (
    input  wire logic clk_sys_i,    // Processor clock.
    output logic      analyse_o,    // Analysis request.
    output logic      reset_pin_o,  // Processor reset pin.
    output logic      chain_o       // Fault from the previous device.
);
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------------
    // Pin sequencing
    // ------------------------------------------------------------------
    // The block has no boot-source input, so the level is simply never moved.
    logic rom_boot_select = 1'b0;

    // All pins idle low so no stray reset or fault is seen at start.
    initial begin
        analyse_o   = 1'b0;
        reset_pin_o = 1'b0;
        chain_o     = 1'b0;
    end

    // Analysis is raised well before any reset that follows it.
    task automatic set_analyse(input logic v);
        analyse_o <= v;
        repeat (20) @(posedge clk_sys_i);
    endtask

    // Long enough to pass the filter; analysis outlives the reset end.
    task automatic reset_pulse();
        reset_pin_o <= 1'b1;
        repeat (RST_HOLD) @(posedge clk_sys_i);
        reset_pin_o <= 1'b0;
        repeat (AN_HOLD) @(posedge clk_sys_i);
    endtask

    // The neighbour's fault pin; the wait covers the synchroniser.
    task automatic chain(input logic v);
        chain_o <= v;
        repeat (5) @(posedge clk_sys_i);
    endtask
endmodule

// [bench/ffh_core_tb.sv]
// Purpose: Self-checking bench for the fault flag and halt control block.
// Assumes: Register reads are scored by a monitor from a queue of notes.
// Notes:   Clock enable is dropped once to show that state freezes.
module ffh_core_tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk_sys_i = 1'b0;  // 20 MHz clock.
    logic        rst_b_i   = 1'b0;  // Held low for ten cycles.
    logic [3:0]  addr      = 4'h0;  // Register address.
    logic [31:0] wd        = '0;    // Write data.
    logic        we        = 1'b0;  // Write strobe.
    logic        re        = 1'b0;  // Read strobe.
    logic        pend      = 1'b0;  // Read data due this cycle.
    logic [6:0]  ev        = '0;    // Event pulses, see dut hookup.
    logic [31:0] ip        = '0;    // Executing instruction address.
    logic [31:0] rdata, areg;
    logic        ce        = 1'b1;  // Clock enable.
    logic        bpj;               // Breakpoint jump enable output.
    logic        an, rp, ch, fault_o, proc_run_o, links_halt_o, fetch, refresh_en_o;
    logic [31:0] eq[$];             // Expected read data, oldest first.
    int          n_fail    = 0;
    int          n_checks  = 0;

    always #25 clk_sys_i = ~clk_sys_i;

    ffh_ctrl_model mdl (.clk_sys_i(clk_sys_i), .analyse_o(an), .reset_pin_o(rp), .chain_o(ch));

    ffh_core dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .ce_i(ce),
        .reg_addr_i(addr), .reg_wdata_i(wd), .reg_we_i(we), .reg_re_i(re),
        .reg_rdata_o(rdata), .chained_fault_i(ch), .analyse_i(an), .reset_pin_i(rp),
        .ovf_i(ev[0]), .div0_i(ev[1]), .bound_i(ev[2]), .fault_test_i(ev[3]),
        .instr_ip_i(ip), .preempt_i(ev[4]), .hp_done_i(ev[5]), .desched_i(ev[6]),
        .fault_o(fault_o), .proc_run_o(proc_run_o), .links_halt_o(links_halt_o),
        .out_fetch_en_o(fetch), .refresh_en_o(refresh_en_o), .bpj_en_o(bpj), .areg_o(areg));

    // ------------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------------
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic print_verdict();
        if (n_fail == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // A spare cycle after each strobe keeps one assignment per time step.
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        addr <= a;
        wd   <= d;
        we   <= 1'b1;
        @(posedge clk_sys_i);
        we <= 1'b0;
        @(posedge clk_sys_i);
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        eq.push_back(e);
        addr <= a;
        re   <= 1'b1;
        @(posedge clk_sys_i);
        re <= 1'b0;
        @(posedge clk_sys_i);
    endtask

    task automatic pls(input int i);
        ev[i] <= 1'b1;
        @(posedge clk_sys_i);
        ev <= '0;
        @(posedge clk_sys_i);
    endtask

    // Read data stand only in the cycle after the strobe, so look there.
    always @(posedge clk_sys_i) begin
        if (pend) cmp("reg_rdata_o", eq.pop_front(), rdata);
        pend <= re;
    end

    // A hang ends the run as a failure.
    initial begin
        repeat (30000) @(posedge clk_sys_i);
        n_fail++;
        print_verdict();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(85));
        repeat (10) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        @(posedge clk_sys_i);
        rd(4'h0, 32'h8);
        rd(4'h2, 32'h0);
        mdl.chain(1'b1);
        cmp("fault_o", 32'h1, {31'h0, fault_o});
        rd(4'h4, 32'h8);
        mdl.chain(1'b0);
        // Pre-emption must hand back the low-priority pair untouched.
        wr(4'h0, 32'hc);
        pls(4);
        rd(4'h4, 32'h21);
        pls(3);
        wr(4'h0, 32'h9);
        rd(4'h4, 32'h20);
        pls(5);
        rd(4'h4, 32'h1);
        rd(4'h0, 32'h8);
        wr(4'h0, 32'h9);
        rd(4'h4, 32'h1);
        pls(3);
        rd(4'h4, 32'h0);
        // Each hardware fault source halts with the pointer two bytes on.
        for (int i = 0; i < 3; i++) begin
            wr(4'h0, 32'h9);
            ip <= $urandom();
            pls(i);
            cmp("proc_run_o", 32'h0, {31'h0, proc_run_o});
            cmp("links_halt_o", 32'h1, {31'h0, links_halt_o});
            rd(4'h8, ip + 32'h2);
            cmp("areg_o", ip + 32'h2, areg);
            mdl.reset_pulse();
            rd(4'h4, 32'h1);
            pls(3);
        end
        // Analysis halt, then a reset that must keep the control flags.
        wr(4'h0, 32'hb);
        ip <= $urandom();
        mdl.set_analyse(1'b1);
        cmp("out_fetch_en_o", 32'h0, {31'h0, fetch});
        pls(6);
        rd(4'h4, 32'h16);
        rd(4'hc, ip + 32'h1);
        cmp("refresh_en_o", 32'h1, {31'h0, refresh_en_o});
        mdl.reset_pulse();
        mdl.set_analyse(1'b0);
        rd(4'h0, 32'hb);
        cmp("bpj_en_o", 32'h1, {31'h0, bpj});
        cmp("proc_run_o", 32'h1, {31'h0, proc_run_o});
        // With the clock enable low an overflow must leave the flag clear.
        ce <= 1'b0;
        pls(0);
        ce <= 1'b1;
        rd(4'h4, 32'h0);
        print_verdict();
    end
endmodule
